// ### core/otgcp_bank.sv
`timescale 1ns/10ps
module otgcp_bank
  import otgcp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // register port from the link command decoder
  input wire logic [5:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // pins and same-clock status
  input wire logic stp_i,
  input wire logic link_busy_i,
  input wire logic hold_state_i,
  input wire logic vbus_cmp_i,
  input wire logic ext_indicator_i,
  // analog and pin controls
  output logic id_line_pullup_enable_o,
  output logic id_sample_en_o,
  output logic dplus_pulldown_enable_o,
  output logic dminus_pulldown_enable_o,
  output logic vbus_discharge_o,
  output logic vbus_charge_o,
  output logic power_switch_out_o,
  output logic vbus_valid_o,
  output logic stp_weak_pullup_o,
  output logic data_weak_pulldown_o,
  output logic link_undriven_o
);

  // whole block state in one word
  typedef struct packed {
    logic [7:0] otg;       // otg control image
    logic prot_dis;        // interface protect disable
    otgcp_prot_t ps;       // protect circuit state
    logic stp_pu;          // weak stp pull-up attached
    logic data_pd;         // weak data pull-downs attached
    logic [7:0] rdata;     // read answer
    logic rvalid;          // read answer strobe
    logic vbus_valid;      // selected vbus valid source
  } otgcp_st_t;

  otgcp_st_t st_reg;
  otgcp_st_t st_next;

  otgcp_sync_if #(.W(OTGCP_SYNC_W)) pins ();

  // pins arrive from outside the clock domain
  assign pins.raw = {ext_indicator_i, vbus_cmp_i, stp_i};

  otgcp_sync #(.W(OTGCP_SYNC_W)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sif(pins)
  );

  // settled pin levels
  logic stp_s;
  logic cmp_s;
  logic ext_s;
  assign stp_s = pins.clean[0];
  assign cmp_s = pins.clean[1];
  assign ext_s = pins.clean[2];

  // address decode for the two register groups
  otgcp_op_t otg_op;
  otgcp_op_t ifc_op;

  always_comb begin
    otg_op = OTGCP_OP_NONE;
    ifc_op = OTGCP_OP_NONE;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        OTGCP_OTG_WR_ADDR: otg_op = OTGCP_OP_WRITE;
        OTGCP_OTG_SET_ADDR: otg_op = OTGCP_OP_SET;
        OTGCP_OTG_CLR_ADDR: otg_op = OTGCP_OP_CLEAR;
        OTGCP_IFC_WR_ADDR: ifc_op = OTGCP_OP_WRITE;
        OTGCP_IFC_SET_ADDR: ifc_op = OTGCP_OP_SET;
        OTGCP_IFC_CLR_ADDR: ifc_op = OTGCP_OP_CLEAR;
        // unmapped writes are dropped
        default: otg_op = OTGCP_OP_NONE;
      endcase
    end
  end

  // next state of registers, protect circuit and outputs
  always_comb begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;

    unique case (otg_op)
      OTGCP_OP_WRITE: st_next.otg = reg_wdata_i & OTGCP_OTG_WMASK;
      OTGCP_OP_SET: st_next.otg = st_reg.otg | (reg_wdata_i & OTGCP_OTG_WMASK);
      OTGCP_OP_CLEAR: st_next.otg = st_reg.otg & ~reg_wdata_i;
      OTGCP_OP_NONE: st_next.otg = st_reg.otg;
    endcase

    // only the protect bit lives in this interface register
    unique case (ifc_op)
      OTGCP_OP_WRITE: st_next.prot_dis = reg_wdata_i[OTGCP_PROT_DIS_BIT];
      OTGCP_OP_SET: st_next.prot_dis = st_reg.prot_dis | reg_wdata_i[OTGCP_PROT_DIS_BIT];
      OTGCP_OP_CLEAR: st_next.prot_dis = st_reg.prot_dis & ~reg_wdata_i[OTGCP_PROT_DIS_BIT];
      OTGCP_OP_NONE: st_next.prot_dis = st_reg.prot_dis;
    endcase

    // protect circuit watches stp by itself
    unique case (st_reg.ps)
      OTGCP_PROT_OFF: begin
        if (!st_next.prot_dis) begin
          st_next.ps = OTGCP_PROT_WATCH;
        end
      end
      OTGCP_PROT_WATCH: begin
        if (st_next.prot_dis) begin
          st_next.ps = OTGCP_PROT_OFF;
        end else if (stp_s && !link_busy_i && !hold_state_i) begin
          st_next.ps = OTGCP_PROT_CLAMP;
        end
      end
      OTGCP_PROT_CLAMP: begin
        if (st_next.prot_dis) begin
          st_next.ps = OTGCP_PROT_OFF;
        end else if (!stp_s || hold_state_i || link_busy_i) begin
          st_next.ps = OTGCP_PROT_WATCH;
        end
      end
      // illegal code falls back to a safe state
      default: st_next.ps = OTGCP_PROT_OFF;
    endcase

    st_next.stp_pu = !st_next.prot_dis;
    st_next.data_pd = (st_next.ps == OTGCP_PROT_CLAMP);

    if (st_reg.otg[OTGCP_EXT_IND_BIT]) begin
      st_next.vbus_valid = ext_s;
    end else begin
      st_next.vbus_valid = cmp_s;
    end

    if (reg_rd_i) begin
      st_next.rvalid = 1'b1;
      if (reg_addr_i == OTGCP_OTG_WR_ADDR || reg_addr_i == OTGCP_OTG_SET_ADDR ||
          reg_addr_i == OTGCP_OTG_CLR_ADDR) begin
        st_next.rdata = st_reg.otg;
      end else if (reg_addr_i == OTGCP_IFC_WR_ADDR || reg_addr_i == OTGCP_IFC_SET_ADDR ||
                   reg_addr_i == OTGCP_IFC_CLR_ADDR) begin
        // other interface bits are not held here and read zero
        st_next.rdata = {st_reg.prot_dis, 7'h00};
      end else begin
        st_next.rdata = 8'h00;
      end
    end
  end

  // one register stage for the whole state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg.otg <= OTGCP_OTG_RESET;
      st_reg.prot_dis <= OTGCP_PROT_DIS_RESET;
      st_reg.ps <= OTGCP_PROT_WATCH;
      st_reg.stp_pu <= 1'b1;
      st_reg.data_pd <= 1'b0;
      st_reg.rdata <= 8'h00;
      st_reg.rvalid <= 1'b0;
      st_reg.vbus_valid <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state flops
  assign reg_rdata_o = st_reg.rdata;
  assign reg_rvalid_o = st_reg.rvalid;
  // id pull-up and sampling share bit 0
  assign id_line_pullup_enable_o = st_reg.otg[OTGCP_ID_PU_BIT];
  assign id_sample_en_o = st_reg.otg[OTGCP_ID_PU_BIT];
  assign dplus_pulldown_enable_o = st_reg.otg[OTGCP_DP_PD_BIT];
  assign dminus_pulldown_enable_o = st_reg.otg[OTGCP_DM_PD_BIT];
  // discharge held until link clears the bit
  assign vbus_discharge_o = st_reg.otg[OTGCP_DISCHG_BIT];
  // charge; link owns the 2ms se0 precheck
  assign vbus_charge_o = st_reg.otg[OTGCP_CHG_BIT];
  assign power_switch_out_o = st_reg.otg[OTGCP_EXT_DRV_BIT];
  assign vbus_valid_o = st_reg.vbus_valid;
  assign stp_weak_pullup_o = st_reg.stp_pu;
  assign data_weak_pulldown_o = st_reg.data_pd;
  assign link_undriven_o = st_reg.data_pd;

  // checks on the registered behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_clamp;
    (!st_reg.prot_dis && ifc_op == OTGCP_OP_NONE && st_reg.ps != OTGCP_PROT_OFF &&
     stp_s && !link_busy_i && !hold_state_i) |=> data_weak_pulldown_o && stp_weak_pullup_o;
  endproperty
  a_clamp: assert property (p_clamp) else $error("data not clamped on high stp");

  property p_disable;
    (ifc_op == OTGCP_OP_WRITE && reg_wdata_i[OTGCP_PROT_DIS_BIT]) |=>
      !stp_weak_pullup_o && !data_weak_pulldown_o;
  endproperty
  a_disable: assert property (p_disable) else $error("protect not removed");

  property p_hold;
    hold_state_i |=> !data_weak_pulldown_o;
  endproperty
  a_hold: assert property (p_hold) else $error("clamp during holding state");

  property p_idpu;
    otg_op == OTGCP_OP_WRITE |=> id_line_pullup_enable_o == $past(reg_wdata_i[OTGCP_ID_PU_BIT]) &&
      id_sample_en_o == id_line_pullup_enable_o;
  endproperty
  a_idpu: assert property (p_idpu) else $error("id pull-up not written");

  property p_dpset;
    (otg_op == OTGCP_OP_SET && reg_wdata_i[OTGCP_DP_PD_BIT]) |=> dplus_pulldown_enable_o;
  endproperty
  a_dpset: assert property (p_dpset) else $error("d+ pull-down not set");

  property p_dmclr;
    (otg_op == OTGCP_OP_CLEAR && reg_wdata_i[OTGCP_DM_PD_BIT]) |=> !dminus_pulldown_enable_o;
  endproperty
  a_dmclr: assert property (p_dmclr) else $error("d- pull-down not cleared");

  property p_dischg;
    ((otg_op == OTGCP_OP_SET && reg_wdata_i[OTGCP_DISCHG_BIT]) ||
     (vbus_discharge_o && (otg_op == OTGCP_OP_NONE || otg_op == OTGCP_OP_SET))) |=>
      vbus_discharge_o;
  endproperty
  a_dischg: assert property (p_dischg) else $error("discharge dropped early");

  property p_chg;
    otg_op == OTGCP_OP_WRITE |=> vbus_charge_o == $past(reg_wdata_i[OTGCP_CHG_BIT]);
  endproperty
  a_chg: assert property (p_chg) else $error("charge bit not written");

  property p_psw;
    otg_op == OTGCP_OP_WRITE |=> power_switch_out_o == $past(reg_wdata_i[OTGCP_EXT_DRV_BIT]);
  endproperty
  a_psw: assert property (p_psw) else $error("power switch level wrong");

  property p_sel;
    st_reg.otg[OTGCP_EXT_IND_BIT] |=> vbus_valid_o == $past(ext_s);
  endproperty
  a_sel: assert property (p_sel) else $error("vbus valid not external");

  property p_read;
    (reg_rd_i && reg_addr_i == OTGCP_OTG_CLR_ADDR) |=>
      reg_rvalid_o && reg_rdata_o == $past(st_reg.otg);
  endproperty
  a_read: assert property (p_read) else $error("otg read wrong");

  property p_setor;
    otg_op == OTGCP_OP_SET |=>
      st_reg.otg == ($past(st_reg.otg) | ($past(reg_wdata_i) & OTGCP_OTG_WMASK));
  endproperty
  a_setor: assert property (p_setor) else $error("set did not or bits");

  property p_clrand;
    otg_op == OTGCP_OP_CLEAR |=>
      st_reg.otg == ($past(st_reg.otg) & ~$past(reg_wdata_i));
  endproperty
  a_clrand: assert property (p_clrand) else $error("clear did not drop bits");

  property p_cmp;
    !st_reg.otg[OTGCP_EXT_IND_BIT] |=> vbus_valid_o == $past(cmp_s);
  endproperty
  a_cmp: assert property (p_cmp) else $error("vbus valid not internal");

  property p_busy;
    link_busy_i |=> !data_weak_pulldown_o;
  endproperty
  a_busy: assert property (p_busy) else $error("clamp during link transfer");

  property p_rvonce;
    !reg_rd_i |=> !reg_rvalid_o;
  endproperty
  a_rvonce: assert property (p_rvonce) else $error("read strobe without read");

  property p_ifrd;
    (reg_rd_i && reg_addr_i == OTGCP_IFC_WR_ADDR) |=>
      reg_rvalid_o && reg_rdata_o == {$past(st_reg.prot_dis), 7'h00};
  endproperty
  a_ifrd: assert property (p_ifrd) else $error("protect bit read wrong");

endmodule // otgcp_bank

// ### inc/otgcp_pkg.sv
// shared constants for the otg control and interface protect bank
package otgcp_pkg;

  // register addresses on the device register port
  localparam logic [5:0] OTGCP_IFC_WR_ADDR = 6'h07;
  localparam logic [5:0] OTGCP_IFC_SET_ADDR = 6'h08;
  localparam logic [5:0] OTGCP_IFC_CLR_ADDR = 6'h09;
  localparam logic [5:0] OTGCP_OTG_WR_ADDR = 6'h0A;
  localparam logic [5:0] OTGCP_OTG_SET_ADDR = 6'h0B;
  localparam logic [5:0] OTGCP_OTG_CLR_ADDR = 6'h0C;

  // otg control field positions
  localparam int OTGCP_ID_PU_BIT = 0;
  localparam int OTGCP_DP_PD_BIT = 1;
  localparam int OTGCP_DM_PD_BIT = 2;
  localparam int OTGCP_DISCHG_BIT = 3;
  localparam int OTGCP_CHG_BIT = 4;
  localparam int OTGCP_EXT_DRV_BIT = 6;
  localparam int OTGCP_EXT_IND_BIT = 7;
  // interface control field position
  localparam int OTGCP_PROT_DIS_BIT = 7;

  // reset values and writable masks
  localparam logic [7:0] OTGCP_OTG_RESET = 8'h06;
  localparam logic [7:0] OTGCP_OTG_WMASK = 8'hDF;
  localparam logic OTGCP_PROT_DIS_RESET = 1'b0;

  // width of the synchronised pin group
  localparam int OTGCP_SYNC_W = 3;

  // register port operation decoded from the address
  typedef enum logic [1:0] {
    OTGCP_OP_WRITE,
    OTGCP_OP_SET,
    OTGCP_OP_CLEAR,
    OTGCP_OP_NONE
  } otgcp_op_t;

  // interface protect circuit states
  typedef enum logic [1:0] {
    OTGCP_PROT_OFF,
    OTGCP_PROT_WATCH,
    OTGCP_PROT_CLAMP
  } otgcp_prot_t;

endpackage

// ### inc/otgcp_sync_if.sv
`timescale 1ns/10ps
// carries raw pin levels into the synchroniser and clean levels back
interface otgcp_sync_if #(
  parameter int W = 3
);
  logic [W-1:0] raw;   // pin levels, asynchronous
  logic [W-1:0] clean; // after two flip-flops

  modport core (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// ### core/otgcp_sync.sv
`timescale 1ns/10ps
// two flip-flop synchroniser for a group of pin levels
module otgcp_sync #(
  parameter int W = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  otgcp_sync_if.core sif
);

  // both stages in one state word
  typedef struct packed {
    logic [W-1:0] first;  // metastable stage, only read by second
    logic [W-1:0] second; // settled stage
  } otgcp_sync_st_t;

  otgcp_sync_st_t st_reg;
  otgcp_sync_st_t st_next;

  // shift the pins through both stages
  always_comb begin
    st_next = st_reg;
    st_next.first = sif.raw;
    st_next.second = st_reg.first;
  end

  // synchronous reset to a quiet level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sif.clean = st_reg.second;

endmodule // otgcp_sync

// ### sim/otgcp_link_model.sv
`timescale 1ns/10ps
// link side of the stp wire: drives it, or lets it go
module otgcp_link_model (
  input wire logic clk_i,
  input wire logic drive_i,  // link actively drives stp
  input wire logic level_i,  // level the link drives
  input wire logic pullup_i, // device weak pull-up attached
  output logic stp_o
);
  logic last_reg = 1'b0; // last wire level, used when floating

  // wire level from all parties
  always_comb begin
    if (drive_i) begin
      stp_o = level_i;
    end else if (pullup_i) begin
      stp_o = 1'b1;
    end else begin
      // nobody holds it: toggle so no stale level passes for a real one
      stp_o = ~last_reg;
    end
  end

  // remember the wire for the floating case
  always_ff @(posedge clk_i) begin
    last_reg <= stp_o;
  end
endmodule // otgcp_link_model

// ### sim/tb_top.sv
`timescale 1ns/10ps
// register port and protect walk-through of the otg bank
module tb_top;
  import otgcp_pkg::*;
  logic clk_i = 1'b0; // 20 MHz
  logic rst_i = 1'b1;
  logic [5:0] addr = 6'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic busy = 1'b0; // link mid-transfer
  logic hold = 1'b0; // holding state
  logic cmp = 1'b0;  // internal comparator
  logic ext = 1'b0;  // external indicator pin
  logic drv = 1'b1;  // link drives stp
  logic lvl = 1'b0;  // level it drives
  logic stp;
  logic [7:0] rdata;
  logic [7:0] e;
  logic rvalid, id_pu, id_smp, dp, dm, dis, chg, power_switch_out, vvld, pu, pd, und;
  int n_fail = 0;
  int n_checks = 0;

  // free-running clock
  always #25 clk_i = ~clk_i;

  otgcp_bank otgcp_bank_i (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .stp_i(stp), .link_busy_i(busy), .hold_state_i(hold),
    .vbus_cmp_i(cmp), .ext_indicator_i(ext), .id_line_pullup_enable_o(id_pu),
    .id_sample_en_o(id_smp), .dplus_pulldown_enable_o(dp),
    .dminus_pulldown_enable_o(dm), .vbus_discharge_o(dis), .vbus_charge_o(chg),
    .power_switch_out_o(power_switch_out), .vbus_valid_o(vvld), .stp_weak_pullup_o(pu),
    .data_weak_pulldown_o(pd), .link_undriven_o(und));

  otgcp_link_model otgcp_link_model_i (.clk_i(clk_i), .drive_i(drv), .level_i(lvl),
    .pullup_i(pu), .stp_o(stp));

  // n edges, then step off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #5;
  endtask

  // byte comparison
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one write strobe; a spare edge so the next strobe is a fresh rise
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask

  // one read strobe; answer valid for exactly one cycle
  task automatic rd_reg(input logic [5:0] a, input logic [7:0] x);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, x);
    cyc(1);
    chk({7'h00, rvalid}, 8'h00);
  endtask

  // control pins against an otg value; bit7 slot carries id sampling
  task automatic ctl(input logic [7:0] x);
    chk({id_smp, power_switch_out, 1'b0, chg, dis, dm, dp, id_pu}, {x[0], x[6], 1'b0, x[4:0]});
  endtask

  // stp pull-up, data pull-down, undriven flag
  task automatic prot(input logic [2:0] x);
    chk({5'h00, pu, pd, und}, {5'h00, x});
  endtask

  // verdict and end of run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    cyc(2);
    rst_i = 1'b0;
    rd_reg(6'h0A, 8'h06);
    ctl(8'h06);
    rd_reg(6'h07, 8'h00);
    prot(3'b100);
    $display("test reset done");
    // each field alone, read back through all three addresses;
    // the link must clear discharge before charging; here one write clears it and sets charge
    // the bench, as link, never reads id grounded after bit 0
    for (int i = 0; i < 8; i++) begin
      e = 8'h01 << i;
      wr_reg(6'h0A, e);
      ctl(e);
      rd_reg(6'h0A + 6'(i % 3), e & 8'hDF);
    end
    $display("test fields done");
    // all but charge: the link never charges while discharging
    wr_reg(6'h0A, 8'hEF);
    rd_reg(6'h0C, 8'hCF);
    wr_reg(6'h0C, 8'h41);
    rd_reg(6'h0B, 8'h8E);
    ctl(8'h8E);
    wr_reg(6'h0B, 8'h21);
    rd_reg(6'h0A, 8'h8F);
    wr_reg(6'h0C, 8'h0E);
    rd_reg(6'h0A, 8'h81);
    ctl(8'h81);
    wr_reg(6'h0B, 8'h0A);
    rd_reg(6'h0B, 8'h8B);
    wr_reg(6'h0D, 8'h00);
    rd_reg(6'h0D, 8'h00);
    // write and read in one cycle: read sees the old value
    addr = 6'h0A;
    wdata = 8'h06;
    wr = 1'b1;
    rd = 1'b1;
    cyc(1);
    wr = 1'b0;
    rd = 1'b0;
    chk(rdata, 8'h8B);
    cyc(1);
    rd_reg(6'h0A, 8'h06);
    $display("test set clear done");
    cmp = 1'b1;
    cyc(4);
    chk({7'h00, vvld}, 8'h01);
    wr_reg(6'h0B, 8'h80);
    cyc(2);
    chk({7'h00, vvld}, 8'h00);
    ext = 1'b1;
    cyc(4);
    chk({7'h00, vvld}, 8'h01);
    wr_reg(6'h0C, 8'h80);
    $display("test indicator done");
    // link lets go of stp: clamp lands on the third edge
    drv = 1'b0;
    cyc(2);
    prot(3'b100);
    cyc(1);
    prot(3'b111);
    hold = 1'b1;
    cyc(1);
    prot(3'b100);
    hold = 1'b0;
    busy = 1'b1;
    cyc(1);
    prot(3'b100);
    busy = 1'b0;
    cyc(1);
    prot(3'b111);
    wr_reg(6'h08, 8'h80);
    prot(3'b000);
    rd_reg(6'h07, 8'h80);
    cyc(3);
    prot(3'b000);
    wr_reg(6'h09, 8'h80);
    rd_reg(6'h09, 8'h00);
    cyc(4);
    prot(3'b111);
    drv = 1'b1;
    cyc(4);
    prot(3'b100);
    // plain write to the interface register
    wr_reg(6'h07, 8'hFF);
    prot(3'b000);
    rd_reg(6'h07, 8'h80);
    wr_reg(6'h07, 8'h00);
    prot(3'b100);
    $display("test protect done");
    end_sim();
  end
endmodule // tb_top
